// file: bench/aes_engine_model.sv
// Key consumer standing in for the engine behind the key port
`timescale 1ns/1ps
module aes_engine_model (
	input wire logic clk,
	input wire logic boot,
	input wire logic [255:0] aes_key,
	output logic [255:0] key_used
);
	// ****************************************
	// Key capture at boot
	// ****************************************
	// The port is the only way the key leaves the store, so capture it here
	always_ff @(posedge clk) begin
		if (boot) begin
			key_used <= aes_key;
		end
	end
endmodule // aes_engine_model

// file: bench/tb.sv
// Self-checking bench for the key store controller
`timescale 1ns/1ps
module tb;
	import key_ram_pkg::*;
	logic clk, rst_b, vbat_rst_b, psel, penable, pwrite, boot, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [255:0] aes_key, key_used, k1, k2;
	int n_errors, n_compared, cyc;

	battery_key_ram_ctrl uut (.clk(clk), .rst_b(rst_b), .vbat_rst_b(vbat_rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .aes_key(aes_key));
	aes_engine_model eng (.clk(clk), .boot(boot), .aes_key(aes_key), .key_used(key_used));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input string name, input logic [255:0] exp, input logic [255:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		psel = 1;
		pwrite = 1;
		paddr = a;
		pwdata = d;
		@(negedge clk);
		penable = 1;
		@(negedge clk);
		psel = 0;
		penable = 0;
		pwrite = 0;
	endtask

	task automatic read(input logic [11:0] a);
		@(negedge clk);
		psel = 1;
		pwrite = 0;
		paddr = a;
		@(negedge clk);
		penable = 1;
		// Data and response are taken at the edge that ends the access phase
		@(posedge clk);
		rd = prdata;
		err = pslverr;
		chk("pready", 1, pready);
		@(negedge clk);
		psel = 0;
		penable = 0;
	endtask

	function automatic logic [31:0] crc_of(input logic [255:0] k);
		logic [31:0] c;
		logic fb;
		c = CRC_INIT;
		for (int i = 0; i < 256; i++) begin
			fb = c[31] ^ k[32 * (i / 32) + 31 - (i % 32)];
			c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
		end
		return c ^ CRC_XOROUT;
	endfunction

	task automatic load_key(input logic [255:0] k, input logic [31:0] crc);
		for (int n = 0; n < 8; n++) wr(KEY_WORD_BASE + 12'(4 * n), k[32 * n +: 32]);
		wr(KEY_CHECK_OFF, crc);
	endtask

	// Polled with a cap so a stuck done flag cannot hang the run
	task automatic wait_done();
		for (int i = 0; i < 20; i++) begin
			read(VERIFY_STATUS_OFF);
			if (rd[0] === 1'b1) break;
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		read(VERIFY_STATUS_OFF);
		chk("status", 0, rd);
		chk("mapped err", 0, err);
		read(KEY_WORD_BASE + 12'h004);
		chk("key read", 0, rd);
		read(KEY_CHECK_OFF);
		chk("check read", 0, rd);
		read(12'h030);
		chk("unmapped err", 1, err);
		read(12'h001);
		chk("misaligned err", 1, err);
		$display("test reset done");
	endtask

	task automatic t_key();
		load_key(k1, crc_of(k1));
		wait_done();
		chk("status good", 3, rd[1:0]);
		chk("aes key", k1, aes_key);
		read(KEY_WORD_BASE);
		chk("key word hidden", 0, rd);
		wr(KEY_WORD_BASE, k2[31:0]);
		read(VERIFY_STATUS_OFF);
		chk("flags cleared", 0, rd);
		load_key(k2, ~crc_of(k2));
		wait_done();
		chk("status bad", 1, rd[1:0]);
		load_key(k2, crc_of(k2));
		wait_done();
		chk("status good 2", 3, rd[1:0]);
		// A key word written while the readback runs must leave both flags clear
		wr(KEY_CHECK_OFF, crc_of(k2));
		wr(KEY_WORD_BASE, k2[31:0]);
		repeat (12) @(negedge clk);
		read(VERIFY_STATUS_OFF);
		chk("aborted check", 0, rd);
		$display("test key done");
	endtask

	task automatic t_general();
		wr(GENERAL_WORD_OFF, 32'hcafe_f00d);
		read(GENERAL_WORD_OFF);
		chk("general rw", 32'hcafe_f00d, rd);
		wr(GENERAL_LOCK_OFF, 32'h0000_0000);
		wr(GENERAL_WORD_OFF, 32'h1234_5678);
		read(GENERAL_WORD_OFF);
		chk("unlocked rw", 32'h1234_5678, rd);
		wr(GENERAL_LOCK_OFF, 32'h0000_0001);
		wr(GENERAL_WORD_OFF, 32'hdead_0001);
		read(GENERAL_WORD_OFF);
		chk("locked ignore", 32'h1234_5678, rd);
		wr(GENERAL_LOCK_OFF, 32'h0000_0000);
		read(GENERAL_LOCK_OFF);
		chk("lock sticks", 1, rd[0]);
		@(negedge clk);
		rst_b = 0;
		@(negedge clk);
		rst_b = 1;
		read(GENERAL_LOCK_OFF);
		chk("lock cleared", 0, rd[0]);
		read(GENERAL_WORD_OFF);
		chk("general kept", 32'h1234_5678, rd);
		boot = 1;
		@(negedge clk);
		boot = 0;
		chk("boot key", k2, key_used);
		$display("test general done");
	endtask

	task automatic print_verdict();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ****************************************
	// Clock, timeout and main sequence
	// ****************************************
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			print_verdict();
		end
	end

	initial begin
		{psel, penable, pwrite, boot, rst_b, vbat_rst_b} = 0;
		paddr = 0;
		pwdata = 0;
		for (int n = 0; n < 8; n++) k1[32 * n +: 32] = 32'h0102_0304 + 32'(n) * 32'h1010_1010;
		k2 = ~{k1[127:0], k1[255:128]};
		repeat (20) @(negedge clk);
		rst_b = 1;
		vbat_rst_b = 1;
		t_reset();
		t_key();
		t_general();
		print_verdict();
	end
endmodule // tb

// file: rtl/battery_key_ram_ctrl.sv
// APB controller for the battery-backed key store with CRC verification
`timescale 1ns/1ps
module battery_key_ram_ctrl
	import key_ram_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic vbat_rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [key_ram_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [255:0] aes_key
);
	import key_ram_pkg::*;

	// ****************************************
	// Address decode
	// ****************************************
	logic is_key;
	logic is_check;
	logic is_status;
	logic is_gen;
	logic is_lock;
	logic mapped;
	logic [IDX_W-1:0] key_idx;
	logic access;
	logic wr_acc;
	logic key_wr;
	logic chk_wr;
	logic gen_wr;
	logic lock_wr;

	always_comb begin
		is_key = 1'b0;
		is_check = 1'b0;
		is_status = 1'b0;
		is_gen = 1'b0;
		is_lock = 1'b0;
		if (paddr[1:0] != 2'b00) begin
			mapped = 1'b0;
		end else if (paddr < KEY_CHECK_OFF) begin
			is_key = 1'b1;
		end else if (paddr == KEY_CHECK_OFF) begin
			is_check = 1'b1;
		end else if (paddr == VERIFY_STATUS_OFF) begin
			is_status = 1'b1;
		end else if (paddr == GENERAL_WORD_OFF) begin
			is_gen = 1'b1;
		end else if (paddr == GENERAL_LOCK_OFF) begin
			is_lock = 1'b1;
		end
		mapped = is_key | is_check | is_status | is_gen | is_lock;
	end

	assign key_idx = IDX_W'(paddr[4:2]);
	assign access = psel & penable;
	assign wr_acc = access & pwrite;
	assign key_wr = wr_acc & is_key;
	assign chk_wr = wr_acc & is_check;
	assign gen_wr = wr_acc & is_gen;
	assign lock_wr = wr_acc & is_lock;

	// Zero wait states; read data is captured in the setup phase
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ****************************************
	// Verification state
	// ****************************************
	verify_state_t state_reg;
	verify_state_t state_next;
	logic [IDX_W-1:0] idx_reg;
	logic [IDX_W-1:0] idx_next;
	logic [31:0] check_reg;
	logic [31:0] check_next;
	logic done_reg;
	logic done_next;
	logic pass_reg;
	logic pass_next;
	logic lock_reg;
	logic lock_next;
	logic [31:0] crc_after;
	logic [31:0] rd_word;
	logic [31:0] general_word;
	logic store_wr;
	logic [IDX_W-1:0] store_idx;

	always_comb begin
		state_next = state_reg;
		idx_next = idx_reg;
		check_next = check_reg;
		done_next = done_reg;
		pass_next = pass_reg;
		case (state_reg)
			ST_IDLE: begin
			end
			ST_READ: begin
				idx_next = idx_reg + 4'h1;
				if (idx_reg == LAST_KEY_IDX) begin
					state_next = ST_IDLE;
					done_next = 1'b1;
					pass_next = (crc_after == check_reg);
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		// A new key word cancels any check in flight; stale results must not show
		if (key_wr) begin
			state_next = ST_IDLE;
			done_next = 1'b0;
			pass_next = 1'b0;
		end
		if (chk_wr) begin
			check_next = pwdata;
			state_next = ST_READ;
			idx_next = '0;
			done_next = 1'b0;
			pass_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= ST_IDLE;
			idx_reg <= '0;
			check_reg <= CHECK_RESET;
			done_reg <= 1'b0;
			pass_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			check_reg <= check_next;
			done_reg <= done_next;
			pass_reg <= pass_next;
		end
	end

	// ****************************************
	// General word lock
	// ****************************************
	always_comb begin
		lock_next = lock_reg;
		if (lock_wr && pwdata[LOCK_SET_BIT]) begin
			lock_next = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_reg <= 1'b0;
		end else begin
			lock_reg <= lock_next;
		end
	end

	// ****************************************
	// Storage and CRC
	// ****************************************
	assign store_wr = key_wr | (gen_wr & ~lock_reg);
	assign store_idx = is_gen ? GENERAL_IDX : key_idx;

	key_word_store u_store (
		.clk(clk),
		.vbat_rst_b(vbat_rst_b),
		.wr_en(store_wr),
		.wr_idx(store_idx),
		.wr_data(pwdata),
		.rd_idx(idx_reg),
		.rd_data(rd_word),
		.aes_key(aes_key),
		.general_word(general_word)
	);

	key_crc_engine u_crc (
		.clk(clk),
		.rst_b(rst_b),
		.start(chk_wr),
		.word_valid(state_reg == ST_READ),
		.word_data(rd_word),
		.crc_after(crc_after)
	);

	// ****************************************
	// Read data
	// ****************************************
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;

	always_comb begin
		prdata_next = prdata_reg;
		if (psel && !penable && !pwrite) begin
			prdata_next = 32'h0000_0000;
			if (is_status) begin
				prdata_next[STATUS_DONE_BIT] = done_reg;
				prdata_next[STATUS_PASS_BIT] = pass_reg;
			end else if (is_gen) begin
				prdata_next = general_word;
			end else if (is_lock) begin
				prdata_next[LOCK_SET_BIT] = lock_reg;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	assign prdata = prdata_reg;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	logic any_wr;
	assign any_wr = key_wr | chk_wr;

	a_key_read_zero: assert property (
		access && !pwrite && is_key |-> prdata == 32'h0000_0000)
		else $error("key word read returned nonzero data");

	a_check_starts: assert property (
		chk_wr |=> state_reg == ST_READ && idx_reg == 4'h0)
		else $error("check write did not start readback");

	a_done_timing: assert property (
		chk_wr ##1 (!any_wr)[*8] |=> done_reg)
		else $error("done not set nine cycles after check write");

	a_done_early: assert property (
		chk_wr ##1 (!any_wr)[*7] |-> !done_reg)
		else $error("done set before readback finished");

	a_pass_match: assert property (
		state_reg == ST_READ && idx_reg == LAST_KEY_IDX && !any_wr
		|=> pass_reg == ($past(crc_after) == check_reg))
		else $error("pass flag disagrees with CRC compare");

	a_flags_clear: assert property (
		any_wr |=> !done_reg && !pass_reg)
		else $error("flags not cleared by key or check write");

	a_lock_sticky: assert property (
		lock_reg |=> lock_reg)
		else $error("lock bit cleared without reset");

	a_gen_locked: assert property (
		lock_reg && gen_wr |=> $stable(general_word))
		else $error("general word changed while locked");

	a_gen_write: assert property (
		gen_wr && !lock_reg |=> general_word == $past(pwdata))
		else $error("general word write not stored");

	a_key_stored: assert property (
		key_wr |=> aes_key[$past(key_idx)*32 +: 32] == $past(pwdata))
		else $error("key word not stored in its slice");

	a_check_read_zero: assert property (
		access && !pwrite && is_check |-> prdata == 32'h0000_0000)
		else $error("check register read returned nonzero data");

	a_status_read: assert property (
		psel && !penable && !pwrite && is_status
		|=> prdata[STATUS_DONE_BIT] == $past(done_reg) && prdata[STATUS_PASS_BIT] == $past(pass_reg))
		else $error("status read does not show the flags");

	a_gen_read: assert property (
		psel && !penable && !pwrite && is_gen |=> prdata == $past(general_word))
		else $error("general word read returned wrong data");

	a_crc_readback: assert property (
		state_reg == ST_READ |-> rd_word == aes_key[idx_reg[2:0]*32 +: 32])
		else $error("readback word differs from the stored key slice");

	a_lock_sets: assert property (
		lock_wr && pwdata[LOCK_SET_BIT] |=> lock_reg)
		else $error("lock bit not set by a write of one");

	a_abort_clears: assert property (
		state_reg == ST_READ && key_wr |=> state_reg == ST_IDLE && !done_reg && !pass_reg)
		else $error("key write did not cancel the running check");

	a_done_hold: assert property (
		done_reg && !any_wr |=> done_reg)
		else $error("done flag dropped without a key or check write");

	c_verify_pass: cover property ($rose(done_reg) && pass_reg);
	c_verify_fail: cover property ($rose(done_reg) && !pass_reg);
	c_locked_write: cover property (lock_reg && gen_wr);
	c_abort_check: cover property (state_reg == ST_READ && key_wr);
	c_restart_check: cover property (state_reg == ST_READ && chk_wr);
endmodule // battery_key_ram_ctrl

// file: rtl/key_crc_engine.sv
// Word-serial CRC-32 over the key readback
`timescale 1ns/1ps
module key_crc_engine
	import key_ram_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic word_valid,
	input wire logic [31:0] word_data,
	output logic [31:0] crc_after
);
	logic [31:0] crc_reg;
	logic [31:0] crc_next;
	logic [31:0] step;
	logic fb;

	// ****************************************
	// One word per cycle, MSB first
	// ****************************************
	always_comb begin
		step = crc_reg;
		fb = 1'b0;
		for (int i = 0; i < 32; i++) begin
			fb = step[31] ^ word_data[31-i];
			step = {step[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
		end
		crc_next = crc_reg;
		if (start) begin
			crc_next = CRC_INIT;
		end else if (word_valid) begin
			crc_next = step;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			crc_reg <= CRC_INIT;
		end else begin
			crc_reg <= crc_next;
		end
	end

	// Final value including this cycle's word, so the compare needs no extra state
	assign crc_after = step ^ CRC_XOROUT;
endmodule // key_crc_engine

// file: rtl/key_ram_pkg.sv
// Constants shared by the battery-backed key store controller
// Functional notes
// - Keep 288 retained bits: a 256-bit key plus one 32-bit general word.
// - Software writes eight write-only key words; each lands in its key slice.
// - A check value write starts a readback of the stored key and a CRC.
// - The computed CRC is compared with the check value software supplied.
// - Status shows a done bit at the end and a pass bit on a match.
// - Key bits leave only on the engine port; register reads never return them.
// - The general word is readable and writable by software.
// - Writing 1 to the lock bit sets it; the general word then ignores writes.
// - Only the platform controller reset clears the lock bit.
// - An updated key is retained and presented to the engine on later boots.
// - All key updates and register accesses go through the APB slave.
package key_ram_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] KEY_WORD_BASE = 12'h000;
	localparam logic [11:0] KEY_CHECK_OFF = 12'h020;
	localparam logic [11:0] VERIFY_STATUS_OFF = 12'h024;
	localparam logic [11:0] GENERAL_WORD_OFF = 12'h028;
	localparam logic [11:0] GENERAL_LOCK_OFF = 12'h02c;

	// ****************************************
	// Fields and storage layout
	// ****************************************
	localparam int KEY_WORDS = 8;
	localparam int STORE_WORDS = 9;
	localparam int IDX_W = 4;
	localparam logic [3:0] GENERAL_IDX = 4'h8;
	localparam logic [3:0] LAST_KEY_IDX = 4'h7;
	localparam int STATUS_DONE_BIT = 0;
	localparam int STATUS_PASS_BIT = 1;
	localparam int LOCK_SET_BIT = 0;

	// ****************************************
	// Reset values and CRC constants
	// ****************************************
	localparam logic [31:0] STORE_RESET = 32'h0000_0000;
	localparam logic [31:0] CHECK_RESET = 32'h0000_0000;
	localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
	localparam logic [31:0] CRC_XOROUT = 32'hffff_ffff;

	typedef enum logic {ST_IDLE, ST_READ} verify_state_t;
endpackage

// file: rtl/key_word_store.sv
// Retained storage of eight key words and the general word
`timescale 1ns/1ps
module key_word_store
	import key_ram_pkg::*;
(
	input wire logic clk,
	input wire logic vbat_rst_b,
	input wire logic wr_en,
	input wire logic [key_ram_pkg::IDX_W-1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [key_ram_pkg::IDX_W-1:0] rd_idx,
	output logic [31:0] rd_data,
	output logic [255:0] aes_key,
	output logic [31:0] general_word
);
	// ****************************************
	// Storage words
	// ****************************************
	// Cleared only by the backup supply reset, so a platform reset keeps the key
	logic [31:0] mem_reg [STORE_WORDS];

	genvar g;
	generate
		for (g = 0; g < STORE_WORDS; g++) begin : g_word
			logic [31:0] word_next;
			always_comb begin
				word_next = mem_reg[g];
				if (wr_en && wr_idx == IDX_W'(g)) begin
					word_next = wr_data;
				end
			end
			always_ff @(posedge clk or negedge vbat_rst_b) begin
				if (!vbat_rst_b) begin
					mem_reg[g] <= STORE_RESET;
				end else begin
					mem_reg[g] <= word_next;
				end
			end
			if (g < KEY_WORDS) begin : g_key
				assign aes_key[g*32 +: 32] = mem_reg[g];
			end
		end
	endgenerate

	assign rd_data = (rd_idx < IDX_W'(STORE_WORDS)) ? mem_reg[rd_idx] : STORE_RESET;
	assign general_word = mem_reg[GENERAL_IDX];
endmodule // key_word_store
